// ### rtl/enc_div_pkg.sv
package enc_div_pkg;
    // Setting widths: the divider settings must hold up to 262144.
    localparam int NUM_W = 19;
    localparam int ZW_W = 16;
    localparam int ACC_W = 24;
    localparam int ZCNT_W = 21;
    localparam int STAT_W = 2;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_NUM = 8'h00;
    localparam logic [7:0] OFS_DEN = 8'h04;
    localparam logic [7:0] OFS_SRC = 8'h08;
    localparam logic [7:0] OFS_ALM_EN = 8'h0C;
    localparam logic [7:0] OFS_ZW = 8'h10;
    localparam logic [7:0] OFS_METHOD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;

    // Reset values of the settings.
    localparam logic [NUM_W-1:0] NUM_RST = 19'h00001;
    localparam logic [NUM_W-1:0] DEN_RST = 19'h00000;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [ZW_W-1:0] ZW_RST = 16'h0000;

    // Output source and phase-B polarity codes, and their bit meaning.
    localparam logic [1:0] SRC_ENC_FWD = 2'h0;
    localparam logic [1:0] SRC_ENC_REV = 2'h1;
    localparam logic [1:0] SRC_EXT_FWD = 2'h2;
    localparam logic [1:0] SRC_EXT_REV = 2'h3;
    localparam int SRC_REVB_BIT = 0;
    localparam int SRC_EXT_BIT = 1;

    // Status, enable and clear bit positions.
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_Z_BIT = 1;

    // Timing: clock, highest output edge rate, unit of the phase-Z width.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ = 20000000;
    localparam int MAX_OUT_EDGE_PPS = 4000000;
    localparam int EDGE_GAP_CYC = (CLK_HZ + MAX_OUT_EDGE_PPS - 1) / MAX_OUT_EDGE_PPS;
    localparam int ZW_UNIT_NS = 1000;
    localparam int ZW_UNIT_CYC = (ZW_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bus codes.
    localparam logic HRESP_OKAY = 1'b0;
endpackage : enc_div_pkg

// ### rtl/quad_step_gen.sv
`timescale 1ns/1ps
// Turns signed edge requests into a two-phase quadrature pattern.
module quad_step_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step,
    input wire logic dir,
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] idx;
    logic [1:0] next_idx;

    // Forward walks 00,10,11,01 so phase A leads; reverse walks back.
    always_comb begin
        next_idx = idx;
        if (step) begin
            next_idx = dir ? 2'(idx + 2'h1) : 2'(idx - 2'h1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx <= 2'h0;
        end else begin
            idx <= next_idx;
        end
    end

    // Position index to pin levels; both phases come from the index flop.
    assign phase_b = idx[1];
    assign phase_a = idx[1] ^ idx[0];
endmodule : quad_step_gen

// ### rtl/encoder_pulse_divider.sv
`timescale 1ns/1ps
// What this block does
// R01 - Output pulses per rotation from one to resolution.
// R02 - Numerator sets A/B pulses per rotation.
// R03 - Denominator gives fractional division when nonzero.
// R04 - Alarm enable zero disables, one enables detection.
// R05 - Width setting sets external phase-Z width.
// R06 - Quadrature external: pass through or regenerate A/B.
// R07 - Encoder, denominator zero: numerator times four.
// R08 - External, denominator zero: one-to-one.
// R09 - Nonzero denominator scales by numerator over denominator.
// R10 - Exactly one phase-Z pulse per rotation.
// R11 - Non-multiple-of-four output: Z not aligned.
// R12 - Unaligned Z lasts one source count.
// R13 - Select code gives source and B polarity.
// R14 - Z held at least width from onset.
// R15 - Alarm raised on output limit when enabled.
// R16 - A and B are quadrature, lead by direction.
module encoder_pulse_divider #(
    parameter int ENC_RES = 1048576,
    parameter int BACKLOG_MAX = 64
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic enc_z,
    input wire logic ext_a,
    input wire logic ext_b,
    input wire logic ext_z,
    output logic out_a,
    output logic out_b,
    output logic out_z,
    output logic regen_alarm,
    output logic irq
);
    import enc_div_pkg::*;

    localparam logic signed [7:0] BL_MAX = 8'(BACKLOG_MAX);
    localparam logic [2:0] GAP_LOAD = 3'(EDGE_GAP_CYC - 1);

    // Settings, bus and status state.
    logic [NUM_W-1:0] dividing_numerator_setting, next_num;
    logic [NUM_W-1:0] dividing_denominator_setting, next_den;
    logic [1:0] output_source_polarity_select, next_src;
    logic regen_limit_alarm_enable, next_alm_en;
    logic [ZW_W-1:0] external_z_width_setting, next_zw;
    logic quadrature_external_regen_method, next_method;
    logic [STAT_W-1:0] status, next_status, irq_en, next_irq_en;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic next_irq;
    // Datapath state.
    logic prev_a, prev_b, prev_z;
    logic signed [ACC_W-1:0] acc, next_acc;
    logic signed [7:0] backlog, next_backlog;
    logic [2:0] gap, next_gap;
    logic z_arm, next_z_arm, zq, next_zq, z_unsync, next_z_unsync;
    logic [ZCNT_W-1:0] zcnt, next_zcnt;
    logic next_out_a, next_out_b, next_out_z, next_alarm;
    // Combinational helpers.
    logic is_ext, pass_thru, src_step, src_dir, div_emit, div_dir;
    logic out_emit, out_dir, alarm_evt, z_evt, gen_a, gen_b;
    logic [1:0] ext_move;
    logic [ACC_W-1:0] add_val, div_val;

    // Position index of a quadrature pair: 00,10,11,01 counts upward.
    function automatic logic [1:0] quad_idx(input logic a, input logic b);
        quad_idx = {b, a ^ b};
    endfunction : quad_idx

    // Read multiplexer; unmapped and write-only words read as zero.
    function automatic logic [31:0] read_word(input logic [7:0] ofs);
        read_word = 32'h00000000;
        case (ofs)
            OFS_NUM: read_word = 32'(dividing_numerator_setting);
            OFS_DEN: read_word = 32'(dividing_denominator_setting);
            OFS_SRC: read_word = 32'(output_source_polarity_select);
            OFS_ALM_EN: read_word = 32'(regen_limit_alarm_enable);
            OFS_ZW: read_word = 32'(external_z_width_setting);
            OFS_METHOD: read_word = 32'(quadrature_external_regen_method);
            OFS_STATUS: read_word = 32'(status);
            OFS_IRQ_EN: read_word = 32'(irq_en);
            default: read_word = 32'h00000000;
        endcase
    endfunction : read_word

    // Bus slave: zero wait states, read data loaded in the address phase.
    always_comb begin
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        if (hsel && hready && htrans[1]) begin
            next_wr_pend = hwrite;
            next_wr_addr = haddr[7:0];
            if (!hwrite) begin
                next_hrdata = read_word(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // Setting writes land in the data phase from the captured address.
    always_comb begin
        next_num = dividing_numerator_setting;
        next_den = dividing_denominator_setting;
        next_src = output_source_polarity_select;
        next_alm_en = regen_limit_alarm_enable;
        next_zw = external_z_width_setting;
        next_method = quadrature_external_regen_method;
        next_irq_en = irq_en;
        if (wr_pend) begin
            case (wr_addr)
                OFS_NUM: next_num = hwdata[NUM_W-1:0]; // [R02]
                OFS_DEN: next_den = hwdata[NUM_W-1:0]; // [R03]
                OFS_SRC: next_src = hwdata[1:0]; // [R13]
                OFS_ALM_EN: next_alm_en = hwdata[0]; // [R04]
                OFS_ZW: next_zw = hwdata[ZW_W-1:0]; // [R05]
                OFS_METHOD: next_method = hwdata[0]; // [R06]
                OFS_IRQ_EN: next_irq_en = hwdata[STAT_W-1:0];
                default: next_num = dividing_numerator_setting;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dividing_numerator_setting <= NUM_RST;
            dividing_denominator_setting <= DEN_RST;
            output_source_polarity_select <= SRC_RST;
            regen_limit_alarm_enable <= 1'b0;
            external_z_width_setting <= ZW_RST;
            quadrature_external_regen_method <= 1'b0;
            irq_en <= '0;
        end else begin
            dividing_numerator_setting <= next_num;
            dividing_denominator_setting <= next_den;
            output_source_polarity_select <= next_src;
            regen_limit_alarm_enable <= next_alm_en;
            external_z_width_setting <= next_zw;
            quadrature_external_regen_method <= next_method;
            irq_en <= next_irq_en;
        end
    end

    // Source selection and decoding of the external quadrature pair.
    always_comb begin
        is_ext = output_source_polarity_select[SRC_EXT_BIT]; // [R13]
        pass_thru = is_ext && !quadrature_external_regen_method; // [R06]
        ext_move = 2'(quad_idx(ext_a, ext_b) - quad_idx(prev_a, prev_b));
        src_step = is_ext ? (ext_move == 2'h1 || ext_move == 2'h3) : enc_step;
        src_dir = is_ext ? (ext_move == 2'h1) : enc_dir;
    end

    // Ratio selection: denominator zero picks the fixed modes.
    always_comb begin
        if (dividing_denominator_setting != '0) begin
            add_val = ACC_W'(dividing_numerator_setting); // [R09]
            div_val = ACC_W'(dividing_denominator_setting); // [R03]
        end else if (is_ext) begin
            add_val = ACC_W'(1); // [R08]
            div_val = ACC_W'(1);
        end else begin
            add_val = ACC_W'(dividing_numerator_setting) << 2; // [R07]
            div_val = ACC_W'(ENC_RES);
        end
    end

    // Fractional accumulator: each source count outside pass-through moves it by add_val,
    // and each wrap past div_val asks for one output edge.
    always_comb begin
        next_acc = acc;
        div_emit = 1'b0;
        div_dir = src_dir;
        if (src_step && !pass_thru) begin
            if (src_dir) begin
                if (acc + $signed(add_val) >= $signed(div_val)) begin
                    next_acc = acc + $signed(add_val) - $signed(div_val); // [R01]
                    div_emit = 1'b1;
                end else begin
                    next_acc = acc + $signed(add_val);
                end
            end else begin
                if (acc - $signed(add_val) < 0) begin
                    next_acc = acc - $signed(add_val) + $signed(div_val);
                    div_emit = 1'b1;
                end else begin
                    next_acc = acc - $signed(add_val);
                end
            end
        end
    end

    // Edge backlog paced to the top output rate; a full backlog is the
    // regeneration limit, not the rate itself.
    always_comb begin
        next_backlog = backlog;
        next_gap = (gap != 3'h0) ? 3'(gap - 3'h1) : gap;
        out_emit = (gap == 3'h0) && (backlog != 8'sh00);
        out_dir = (backlog > 8'sh00);
        if (out_emit) begin
            next_backlog = out_dir ? 8'(backlog - 8'sh01) : 8'(backlog + 8'sh01);
            next_gap = GAP_LOAD;
        end
        alarm_evt = 1'b0;
        if (div_emit) begin
            if ((div_dir && backlog >= BL_MAX) || (!div_dir && backlog <= -BL_MAX)) begin
                alarm_evt = regen_limit_alarm_enable; // [R15] [R04]
            end else begin
                next_backlog = div_dir ? 8'(next_backlog + 8'sh01) : 8'(next_backlog - 8'sh01);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= '0;
            backlog <= 8'sh00;
            gap <= 3'h0;
        end else begin
            acc <= next_acc;
            backlog <= next_backlog;
            gap <= next_gap;
        end
    end

    // Paced edges drive the quadrature pattern.
    quad_step_gen u_quad (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(out_emit),
        .dir(out_dir),
        .phase_a(gen_a),
        .phase_b(gen_b)
    );

    // Phase Z: aligned to an output edge, a source count wide when the
    // output count per turn is not a multiple of four, or stretched from
    // the external onset.
    always_comb begin
        logic [47:0] prod;
        logic [47:0] quo;
        prod = 48'(dividing_numerator_setting) * 48'(ENC_RES);
        quo = 48'h0;
        next_z_unsync = 1'b0;
        if (dividing_denominator_setting != '0) begin
            quo = prod / 48'(dividing_denominator_setting);
            next_z_unsync = (quo[1:0] != 2'h0) ||
                (prod % 48'(dividing_denominator_setting) != 48'h0); // [R11]
        end
        next_z_arm = z_arm;
        next_zq = zq;
        next_zcnt = (zcnt != '0) ? ZCNT_W'(zcnt - 1'b1) : zcnt;
        z_evt = 1'b0;
        if (is_ext) begin
            z_evt = ext_z && !prev_z;
            if (z_evt) begin
                next_zcnt = ZCNT_W'(external_z_width_setting * ZW_UNIT_CYC); // [R14] [R05]
            end
            next_zq = ext_z || (next_zcnt != '0); // [R14]
            next_z_arm = 1'b0;
        end else begin
            z_evt = enc_z; // [R10]
            next_zcnt = '0;
            if (z_unsync) begin
                if (enc_z) begin
                    next_zq = 1'b1; // [R12]
                end else if (src_step) begin
                    next_zq = 1'b0; // [R12]
                end
                next_z_arm = 1'b0;
            end else begin
                if (enc_z) begin
                    next_z_arm = 1'b1;
                end
                if (out_emit) begin
                    if (zq) begin
                        next_zq = 1'b0;
                    end else if (z_arm) begin
                        next_zq = 1'b1; // [R10]
                        next_z_arm = enc_z;
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            z_arm <= 1'b0;
            zq <= 1'b0;
            z_unsync <= 1'b0;
            zcnt <= '0;
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_z <= 1'b0;
        end else begin
            z_arm <= next_z_arm;
            zq <= next_zq;
            z_unsync <= next_z_unsync;
            zcnt <= next_zcnt;
            prev_a <= ext_a;
            prev_b <= ext_b;
            prev_z <= ext_z;
        end
    end

    // Output pins, status and interrupt; a new event beats a clear.
    always_comb begin
        logic [STAT_W-1:0] clr;
        logic [STAT_W-1:0] evt;
        clr = (wr_pend && wr_addr == OFS_IRQ_CLR) ? hwdata[STAT_W-1:0] : '0;
        evt = '0;
        evt[STAT_ALARM_BIT] = alarm_evt;
        evt[STAT_Z_BIT] = z_evt;
        next_status = (status & ~clr) | evt;
        next_irq = |(next_status & irq_en);
        next_alarm = next_status[STAT_ALARM_BIT];
        next_out_a = pass_thru ? ext_a : gen_a; // [R06] [R16]
        next_out_b = (pass_thru ? ext_b : gen_b) ^
            output_source_polarity_select[SRC_REVB_BIT]; // [R13] [R16]
        next_out_z = zq;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            irq <= 1'b0;
            regen_alarm <= 1'b0;
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_z <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
            regen_alarm <= next_alarm;
            out_a <= next_out_a;
            out_b <= next_out_b;
            out_z <= next_out_z;
        end
    end
endmodule : encoder_pulse_divider

// ### verification/enc_div_props.sv
`timescale 1ns/1ps
module enc_div_props #(
    parameter int ENC_RES = 1048576,
    parameter int BACKLOG_MAX = 64
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic out_z,
    input wire logic regen_alarm,
    input wire logic irq
);
    import enc_div_pkg::*;
    logic [2:0] wr_age;
    logic [2:0] next_wr_age;
    logic rd_go;
    logic wr_go;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Bus transfers taken at this edge.
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;
    // Cycles since the last taken write.
    always_comb begin
        next_wr_age = wr_age;
        if (wr_go) begin
            next_wr_age = 3'h0;
        end else if (wr_age != 3'h7) begin
            next_wr_age = wr_age + 3'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_age <= 3'h0;
        end else begin
            wr_age <= next_wr_age;
        end
    end
    // An output step is a change on either phase; a quiet cycle has none.
    sequence out_step;
        (out_a != $past(out_a)) || (out_b != $past(out_b));
    endsequence
    sequence out_quiet;
        $stable(out_a) && $stable(out_b);
    endsequence
    AST_READY_ZERO_WAIT: assert property (hreadyout)
        else $error("hreadyout low");
    AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("hresp not okay");
    AST_RESET_OUTPUTS: assert property (!$past(hresetn) |-> !out_a && !out_b && !out_z && !irq)
        else $error("outputs not idle after reset");
    AST_QUAD_ONE_PHASE: assert property (!((out_a != $past(out_a)) && (out_b != $past(out_b))))
        else $error("both phases moved at once");
    AST_STEP_SPACING: assert property (out_step |=> out_quiet [*4])
        else $error("output steps too close");
    AST_HRDATA_HOLD: assert property (!$past(rd_go) |-> $stable(hrdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (rd_go && haddr[31:8] == 24'h0
        && (haddr[7:0] == OFS_IRQ_CLR || haddr[7:0] > 8'h20) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_ALARM_STICKY: assert property (regen_alarm && wr_age > 3'h3 |=> regen_alarm)
        else $error("alarm dropped without a clear");
    AST_IRQ_STICKY: assert property (irq && wr_age > 3'h3 |=> irq)
        else $error("irq dropped without a write");
endmodule : enc_div_props

bind encoder_pulse_divider enc_div_props #(.ENC_RES(ENC_RES), .BACKLOG_MAX(BACKLOG_MAX))
    enc_div_props_inst (.*);

// ### verification/host_counter_model.sv
`timescale 1ns/1ps
module host_counter_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic out_z,
    output int pos,
    output int bad,
    output int z_count,
    output int z_width
);
    logic [1:0] prev;
    logic [1:0] cur;
    int z_run;
    // Phase index of the pair: 00, 10, 11, 01 count upwards.
    assign cur = {out_b, out_a ^ out_b};
    initial begin
        pos = 0;
        bad = 0;
        z_count = 0;
        z_width = 0;
        z_run = 0;
    end
    // Count quadrature steps signed; a jump by two states is illegal.
    always @(posedge hclk) begin
        if (!hresetn) begin
            prev <= 2'h0;
        end else if (cur != prev) begin
            prev <= cur;
            if (cur == prev + 2'h1) begin
                pos <= pos + 1;
            end else if (cur == prev - 2'h1) begin
                pos <= pos - 1;
            end else begin
                bad <= bad + 1;
            end
        end
    end
    // Count index onsets, so a pulse still high at the end of a turn counts.
    always @(posedge hclk) begin
        if (out_z) begin
            if (z_run == 0) begin
                z_count <= z_count + 1;
            end
            z_run <= z_run + 1;
        end else if (z_run != 0) begin
            z_width <= z_run;
            z_run <= 0;
        end
    end
endmodule : host_counter_model

// ### verification/tb_encoder_pulse_divider.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("CHECK FAILED t=%0t %s", $time, msg); \
        end \
    end
module tb_encoder_pulse_divider;
    import enc_div_pkg::*;
    localparam int RES = 64;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic enc_step = 1'b0;
    logic enc_dir = 1'b1;
    logic enc_z = 1'b0;
    logic ext_a = 1'b0;
    logic ext_b = 1'b0;
    logic ext_z = 1'b0;
    logic out_a;
    logic out_b;
    logic out_z;
    logic regen_alarm;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    int pos;
    int bad;
    int z_count;
    int z_width;
    // Clock at 20 MHz.
    initial begin
        forever #25 hclk = ~hclk;
    end
    encoder_pulse_divider #(.ENC_RES(RES), .BACKLOG_MAX(8)) encoder_pulse_divider_inst (
        .hready(hreadyout), .*
    );
    host_counter_model host_counter_model_inst (.*);
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic done(input string n);
        $display("%s finished, mismatches so far %0d", n, miscompares);
    endtask : done
    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        `CHK(d, e, m)
    endtask : rd_chk
    task automatic setup(input logic [1:0] s, input int n, input int d, input logic m);
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        wr(OFS_NUM, 32'(n));
        wr(OFS_DEN, 32'(d));
        wr(OFS_SRC, {30'h0, s});
        wr(OFS_METHOD, {31'h0, m});
        repeat (8) @(posedge hclk);
    endtask : setup
    // One motor turn, with the index one cycle after the middle count.
    task automatic enc_case(input logic [1:0] s, input int n, input int d, input logic dir,
                            input int exp);
        int p0;
        int z0;
        setup(s, n, d, 1'b0);
        p0 = pos;
        z0 = z_count;
        for (int i = 0; i < RES; i++) begin
            @(posedge hclk);
            enc_step <= 1'b1;
            enc_dir <= dir;
            @(posedge hclk);
            enc_step <= 1'b0;
            enc_z <= (i == RES / 2);
            @(posedge hclk);
            enc_z <= 1'b0;
            repeat (5) @(posedge hclk);
        end
        repeat (80) @(posedge hclk);
        `CHK(pos - p0, exp, "steps per turn")
        `CHK(z_count - z0, 1, "index per turn")
        `CHK(bad, 0, "illegal step")
    endtask : enc_case
    task automatic reg_case();
        logic [7:0] ofs [8] = '{OFS_NUM, OFS_DEN, OFS_SRC, OFS_ALM_EN, OFS_ZW,
                                OFS_METHOD, OFS_STATUS, OFS_IRQ_EN};
        setup(2'h0, 1, 0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rd_chk(ofs[i], (i == 0) ? 32'h1 : 32'h0, "reset value");
        end
        wr(OFS_NUM, 32'h40000);
        rd_chk(OFS_NUM, 32'h40000, "numerator top");
        wr(OFS_DEN, 32'h40000);
        rd_chk(OFS_DEN, 32'h40000, "denominator top");
        wr(OFS_STATUS, 32'hFFFFFFFF);
        rd_chk(OFS_STATUS, 32'h0, "status read only");
        rd_chk(8'h40, 32'h0, "unmapped read");
        rd_chk(OFS_IRQ_CLR, 32'h0, "clear reads zero");
        done("reg_case");
    endtask : reg_case
    task automatic int_case();
        enc_case(2'h0, 4, 0, 1'b1, 4 * 4);
        enc_case(2'h1, 4, 0, 1'b1, -(4 * 4));
        enc_case(2'h0, 1, 0, 1'b0, -(1 * 4));
        enc_case(2'h0, RES / 4, 0, 1'b1, RES);
        done("int_case");
    endtask : int_case
    task automatic frac_case();
        logic ok;
        enc_case(2'h0, 3, 4, 1'b1, RES * 3 / 4);
        enc_case(2'h0, 3, 32, 1'b1, RES * 3 / 32);
        ok = z_width > 0 && z_width < 16;
        `CHK(ok, 1'b1, "narrow index")
        done("frac_case");
    endtask : frac_case
    // Four forward periods on the external pair, with no index.
    task automatic ext_run(input logic [1:0] s, input logic m, input int exp);
        int p0;
        logic [1:0] q;
        setup(s, 1, 0, m);
        p0 = pos;
        for (int i = 1; i <= 16; i++) begin
            q = 2'(i);
            @(posedge hclk);
            ext_a <= q[1] ^ q[0];
            ext_b <= q[1];
            repeat (7) @(posedge hclk);
        end
        repeat (80) @(posedge hclk);
        `CHK(pos - p0, exp, "external steps")
    endtask : ext_run
    task automatic ext_case();
        ext_run(2'h2, 1'b0, 16);
        ext_run(2'h3, 1'b0, -16);
        ext_run(2'h2, 1'b1, 16);
        done("ext_case");
    endtask : ext_case
    task automatic zwidth_case();
        int z0;
        logic ok;
        setup(2'h2, 1, 0, 1'b0);
        wr(OFS_ZW, 32'h2);
        z0 = z_count;
        @(posedge hclk);
        ext_z <= 1'b1;
        repeat (3) @(posedge hclk);
        ext_z <= 1'b0;
        repeat (80) @(posedge hclk);
        ok = z_width >= 2 * ZW_UNIT_CYC && z_width <= 2 * ZW_UNIT_CYC + 2;
        `CHK(z_count - z0, 1, "external index")
        `CHK(ok, 1'b1, "stretched index")
        done("zwidth_case");
    endtask : zwidth_case
    // A burst of counts overruns the backlog.
    task automatic burst(input logic en);
        setup(2'h0, RES / 4, 0, 1'b0);
        wr(OFS_ALM_EN, {31'h0, en});
        @(posedge hclk);
        enc_step <= 1'b1;
        repeat (40) @(posedge hclk);
        enc_step <= 1'b0;
        repeat (200) @(posedge hclk);
        `CHK(regen_alarm, en, "alarm after overrun")
        rd_chk(OFS_STATUS, {31'h0, en}, "status after overrun");
    endtask : burst
    task automatic alarm_case();
        burst(1'b0);
        burst(1'b1);
        `CHK(irq, 1'b0, "irq disabled")
        wr(OFS_IRQ_EN, 32'h2);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b0, "irq masked")
        wr(OFS_IRQ_EN, 32'h1);
        repeat (2) @(posedge hclk);
        `CHK(irq, 1'b1, "irq raised")
        wr(OFS_IRQ_CLR, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0, "irq cleared")
        `CHK(regen_alarm, 1'b0, "alarm cleared")
        rd_chk(OFS_STATUS, 32'h0, "status cleared");
        done("alarm_case");
    endtask : alarm_case
    // Main sequence.
    initial begin
        reg_case();
        int_case();
        frac_case();
        ext_case();
        zwidth_case();
        alarm_case();
        results();
    end
    // Watchdog.
    initial begin
        repeat (40000) @(posedge hclk);
        miscompares++;
        results();
    end
endmodule : tb_encoder_pulse_divider
